// ==== lcr_pkg.sv ====
// constants, types and register map of the serial link control registers
// assumes a 32-bit apb master; registers sit one per aligned word at four times their index
package lcr_pkg;

	localparam int unsigned LCR_DATA_W = 32;
	localparam int unsigned LCR_ADDR_W = 12;

	// register indices, byte address is four times the index
	localparam logic [9:0] LCR_IDX_ENABLE = 10'h200;
	localparam logic [9:0] LCR_IDX_MODE   = 10'h201;
	localparam logic [9:0] LCR_IDX_KM1    = 10'h202;
	localparam logic [9:0] LCR_IDX_SYNC   = 10'h203;
	localparam logic [9:0] LCR_IDX_FMT    = 10'h204;
	localparam logic [9:0] LCR_IDX_CAL    = 10'h210;
	localparam logic [9:0] LCR_IDX_STATUS = 10'h211;

	// reset values
	localparam logic [7:0] LCR_RST_ENABLE = 8'h01;
	localparam logic [7:0] LCR_RST_MODE   = 8'h00;
	localparam logic [7:0] LCR_RST_KM1    = 8'h1F;
	localparam logic [7:0] LCR_RST_SYNC   = 8'h01;
	localparam logic [7:0] LCR_RST_FMT    = 8'h03;
	localparam logic [7:0] LCR_RST_CAL    = 8'h00;

	// field layout
	localparam int unsigned LCR_EN_BIT     = 0;
	localparam int unsigned LCR_CAL_BIT    = 0;
	localparam int unsigned LCR_SYNC_BIT   = 0;
	localparam int unsigned LCR_MODE_W     = 6;
	localparam int unsigned LCR_FMT_W      = 5;
	localparam int unsigned LCR_SSEL_LSB   = 2;
	localparam int unsigned LCR_SSEL_W     = 2;
	localparam logic [1:0]  LCR_SSEL_SE    = 2'h0;
	localparam logic [1:0]  LCR_SSEL_TMSTP = 2'h1;
	localparam logic [1:0]  LCR_SSEL_NONE  = 2'h2;

	// status word layout
	localparam int unsigned LCR_ST_RUN_BIT  = 0;
	localparam int unsigned LCR_ST_SYNC_BIT = 1;
	localparam int unsigned LCR_ST_64B_BIT  = 2;
	localparam int unsigned LCR_ST_K_LSB    = 16;

	// multiframe length and mode table
	localparam int unsigned LCR_K_W     = 12;
	localparam logic [11:0] LCR_K_SCALE = 12'h100;
	localparam int unsigned LCR_MODES   = 64;
	localparam int unsigned LCR_E_W     = 4;
	localparam int unsigned LCR_F_W     = 5;
	localparam logic [63:0]  LCR_MODE_IS64_DEF = 64'h0;
	localparam logic [255:0] LCR_MODE_E_DEF    = {64{4'h1}};
	localparam logic [319:0] LCR_MODE_F_DEF    = {64{5'h01}};

	typedef enum logic [1:0] {
		LCR_ST_OFF  = 2'b00,
		LCR_ST_LOAD = 2'b01,
		LCR_ST_CALC = 2'b10,
		LCR_ST_RUN  = 2'b11
	} lcr_state_e;

endpackage

// ==== lcr_mode_decode.sv ====
// per-mode lookup of link layer type and the e and f figures
// assumes the mode input is steady while the subsystem is enabled
`timescale 1ns/1ps
`default_nettype none
module lcr_mode_decode #(
	parameter int unsigned             MODES  = lcr_pkg::LCR_MODES,
	parameter int unsigned             E_W    = lcr_pkg::LCR_E_W,
	parameter int unsigned             F_W    = lcr_pkg::LCR_F_W,
	parameter logic [MODES-1:0]        IS64   = lcr_pkg::LCR_MODE_IS64_DEF,
	parameter logic [MODES*E_W-1:0]    E_TAB  = lcr_pkg::LCR_MODE_E_DEF,
	parameter logic [MODES*F_W-1:0]    F_TAB  = lcr_pkg::LCR_MODE_F_DEF
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic [5:0]            mode,
	output logic                       is_64b66b,
	output logic [E_W-1:0]             e_value,
	output logic [F_W-1:0]             f_value
);
	typedef struct packed {
		logic           is64;
		logic [E_W-1:0] e;
		logic [F_W-1:0] f;
	} lcr_dec_s;

	lcr_dec_s       dec_r;
	lcr_dec_s       dec_nxt;
	logic           is64_tab [MODES];
	logic [E_W-1:0] e_tab    [MODES];
	logic [F_W-1:0] f_tab    [MODES];

	for (genvar i = 0; i < MODES; i++) begin : g_tab
		assign is64_tab[i] = IS64[i];
		assign e_tab[i]    = E_TAB[i*E_W +: E_W];
		assign f_tab[i]    = F_TAB[i*F_W +: F_W];
	end

	always_comb begin
		dec_nxt.is64 = is64_tab[mode];
		dec_nxt.e    = e_tab[mode];
		dec_nxt.f    = f_tab[mode];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_r <= '0;
		end else begin
			dec_r <= dec_nxt;
		end
	end

	assign is_64b66b = dec_r.is64;
	assign e_value   = dec_r.e;
	assign f_value   = dec_r.f;
endmodule
`default_nettype wire

// ==== lcr_k_calc.sv ====
// effective frames per multiframe from the stored length or from e and f
// assumes inputs settle one cycle before the result is used
`timescale 1ns/1ps
`default_nettype none
module lcr_k_calc #(
	parameter int unsigned E_W = lcr_pkg::LCR_E_W,
	parameter int unsigned F_W = lcr_pkg::LCR_F_W,
	parameter int unsigned K_W = lcr_pkg::LCR_K_W
) (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           is_64b66b,
	input  wire logic [E_W-1:0] e_value,
	input  wire logic [F_W-1:0] f_value,
	input  wire logic [7:0]     km1,
	output logic [K_W-1:0]      k_value
);
	typedef struct packed {
		logic [K_W-1:0] k;
	} lcr_kc_s;

	lcr_kc_s        kc_r;
	lcr_kc_s        kc_nxt;
	logic [K_W-1:0] scaled;

	always_comb begin
		scaled = K_W'(lcr_pkg::LCR_K_SCALE * K_W'(e_value));
		if (is_64b66b) begin
			// zero f is illegal in the table, fall back to no division
			kc_nxt.k = (f_value == '0) ? scaled : K_W'(scaled / K_W'(f_value)); // RL12
		end else begin
			kc_nxt.k = K_W'(km1) + K_W'(1); // RL10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kc_r <= '0;
		end else begin
			kc_r <= kc_nxt;
		end
	end

	assign k_value = kc_r.k;
endmodule
`default_nettype wire

// ==== lcr_regs.sv ====
// apb register bank and bring-up control of the serial output subsystem
// assumes synchronous sync pins and a single 250 mhz pclk
// How it works
// RL1 - enable bit 0 switches the serial interface; resets to 1, enabled
// RL2 - while disabled, hold subsystem in reset and serializers powered down
// RL3 - while disabled, gate off subsystem clocks
// RL4 - while disabled, hold boundary counter in reset so sysref cannot align
// RL5 - host clears enable before changing other link configuration
// RL6 - host sets calibration enable before setting subsystem enable
// RL7 - host clears subsystem enable before clearing calibration enable
// RL8 - mode field is bits 5:0, bits 7:6 reserved, reset 0
// RL9 - host changes mode only while enable and calibration are both 0
// RL10 - length field holds k minus one; device uses stored value plus one
// RL11 - length field resets to 31, giving 32 frames
// RL12 - 64b/66b modes ignore length field and use 256 times e over f
// RL13 - host writes length field only while disabled
// RL14 - writing 0 to sync bit raises a sync request like the pin
// RL15 - software keeps sync bit at 1 normally; resets to 1
// RL16 - software sync request works whatever the source select holds
// RL17 - a stuck low pin keeps request unless select is 2; code also ignores the pins at select 3
// RL18 - software writes reserved bits as zero
// RL19 - select 2 ignores both pins, software bit alone requests
// RL20 - mode and length are applied when enable rises, bring-up from reset
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lcr_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sync_pin_se_n,
	input  wire logic        sync_pin_tmstp_n,
	output logic             subsystem_reset_n,
	output logic             serdes_power_down,
	output logic             subsystem_clock_enable,
	output logic             boundary_counter_reset,
	output logic [5:0]       applied_output_mode,
	output logic             applied_is_64b66b,
	output logic [11:0]      effective_k,
	output logic             sync_request,
	output logic             calibration_enable,
	output logic [4:0]       link_format_control
);
	localparam logic [11:0] ADDR_ENABLE = {lcr_pkg::LCR_IDX_ENABLE, 2'b00};
	localparam logic [11:0] ADDR_MODE   = {lcr_pkg::LCR_IDX_MODE, 2'b00};
	localparam logic [11:0] ADDR_KM1    = {lcr_pkg::LCR_IDX_KM1, 2'b00};
	localparam logic [11:0] ADDR_SYNC   = {lcr_pkg::LCR_IDX_SYNC, 2'b00};
	localparam logic [11:0] ADDR_FMT    = {lcr_pkg::LCR_IDX_FMT, 2'b00};
	localparam logic [11:0] ADDR_CAL    = {lcr_pkg::LCR_IDX_CAL, 2'b00};
	localparam logic [11:0] ADDR_STATUS = {lcr_pkg::LCR_IDX_STATUS, 2'b00};

	typedef struct packed {
		logic                  en;
		logic [5:0]            mode;
		logic [7:0]            km1;
		logic                  sync_n;
		logic [4:0]            fmt;
		logic                  cal;
		lcr_pkg::lcr_state_e   state;
		logic [5:0]            mode_app;
		logic [7:0]            km1_app;
		logic [31:0]           rdata;
		logic                  ready;
		logic                  slverr;
		logic                  sync_req;
		logic                  sub_rst_n;
		logic                  pwr_down;
		logic                  clk_en;
		logic                  bnd_rst;
	} lcr_regs_s;

	lcr_regs_s   r_r;
	lcr_regs_s   r_nxt;
	logic        setup;
	logic        access;
	logic        wr_lane0;
	logic        hit;
	logic [31:0] rd_word;
	logic [1:0]  sync_sel;
	logic        pin_req;
	logic        dec_is64;
	logic [3:0]  dec_e;
	logic [4:0]  dec_f;
	logic [11:0] k_val;

	// the decoder reads only the applied mode, so a late host write cannot
	// disturb a running link
	lcr_mode_decode u_mode_decode (
		.pclk      (pclk),
		.presetn   (presetn),
		.mode      (r_r.mode_app),
		.is_64b66b (dec_is64),
		.e_value   (dec_e),
		.f_value   (dec_f)
	);

	lcr_k_calc u_k_calc (
		.pclk      (pclk),
		.presetn   (presetn),
		.is_64b66b (dec_is64),
		.e_value   (dec_e),
		.f_value   (dec_f),
		.km1       (r_r.km1_app),
		.k_value   (k_val)
	);

	assign setup    = psel && !penable;
	assign access   = psel && penable && r_r.ready;
	assign wr_lane0 = access && pwrite && pstrb[0];
	assign sync_sel = r_r.fmt[lcr_pkg::LCR_SSEL_LSB +: lcr_pkg::LCR_SSEL_W];

	always_comb begin
		hit = 1'b1;
		rd_word = '0;
		unique case (paddr)
			ADDR_ENABLE: begin
				rd_word[lcr_pkg::LCR_EN_BIT] = r_r.en;
			end
			ADDR_MODE: begin
				rd_word[5:0] = r_r.mode; // RL8
			end
			ADDR_KM1: begin
				rd_word[7:0] = r_r.km1;
			end
			ADDR_SYNC: begin
				rd_word[lcr_pkg::LCR_SYNC_BIT] = r_r.sync_n;
			end
			ADDR_FMT: begin
				rd_word[4:0] = r_r.fmt;
			end
			ADDR_CAL: begin
				rd_word[lcr_pkg::LCR_CAL_BIT] = r_r.cal;
			end
			ADDR_STATUS: begin
				rd_word[lcr_pkg::LCR_ST_RUN_BIT] = (r_r.state == lcr_pkg::LCR_ST_RUN);
				rd_word[lcr_pkg::LCR_ST_SYNC_BIT] = r_r.sync_req;
				rd_word[lcr_pkg::LCR_ST_64B_BIT] = dec_is64;
				rd_word[lcr_pkg::LCR_ST_K_LSB +: 12] = k_val;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// pin choice; select 3 is treated like 2 so no pin can hold a request
	always_comb begin
		unique case (sync_sel)
			lcr_pkg::LCR_SSEL_SE: begin
				pin_req = !sync_pin_se_n;
			end
			lcr_pkg::LCR_SSEL_TMSTP: begin
				pin_req = !sync_pin_tmstp_n;
			end
			default: begin
				pin_req = 1'b0; // RL19
			end
		endcase
	end

	always_comb begin
		r_nxt = r_r;

		// apb: answer one cycle after setup, data and error ready with pready
		r_nxt.ready = setup;
		if (setup) begin
			r_nxt.rdata  = pwrite ? '0 : rd_word;
			r_nxt.slverr = !hit;
		end else if (access) begin
			r_nxt.rdata  = '0;
			r_nxt.slverr = 1'b0;
		end

		// reserved bits are dropped on write and read back as zero
		if (wr_lane0 && hit) begin // RL18
			unique case (paddr)
				ADDR_ENABLE: begin
					r_nxt.en = pwdata[lcr_pkg::LCR_EN_BIT]; // RL1
				end
				ADDR_MODE: begin
					r_nxt.mode = pwdata[5:0]; // RL8
				end
				ADDR_KM1: begin
					r_nxt.km1 = pwdata[7:0]; // RL10
				end
				ADDR_SYNC: begin
					r_nxt.sync_n = pwdata[lcr_pkg::LCR_SYNC_BIT]; // RL14
				end
				ADDR_FMT: begin
					r_nxt.fmt = pwdata[4:0];
				end
				ADDR_CAL: begin
					r_nxt.cal = pwdata[lcr_pkg::LCR_CAL_BIT];
				end
				default: begin
					r_nxt.en = r_r.en;
				end
			endcase
		end

		// bring-up sequence; mode and length writes while enabled are kept but not applied
		unique case (r_r.state)
			lcr_pkg::LCR_ST_OFF: begin
				if (r_r.en) begin
					r_nxt.mode_app = r_r.mode; // RL20
					r_nxt.km1_app  = r_r.km1; // RL20
					r_nxt.state    = lcr_pkg::LCR_ST_LOAD;
				end
			end
			lcr_pkg::LCR_ST_LOAD: begin
				r_nxt.state = r_r.en ? lcr_pkg::LCR_ST_CALC : lcr_pkg::LCR_ST_OFF;
			end
			lcr_pkg::LCR_ST_CALC: begin
				r_nxt.state = r_r.en ? lcr_pkg::LCR_ST_RUN : lcr_pkg::LCR_ST_OFF;
			end
			lcr_pkg::LCR_ST_RUN: begin
				if (!r_r.en) begin
					r_nxt.state = lcr_pkg::LCR_ST_OFF; // RL5
				end
			end
		endcase

		// reset held until k is settled, so bring-up starts from known values
		r_nxt.sub_rst_n = (r_nxt.state == lcr_pkg::LCR_ST_RUN); // RL2
		// follows the state, so power-down and clock gate switch on one edge
		r_nxt.pwr_down  = (r_nxt.state == lcr_pkg::LCR_ST_OFF); // RL2
		r_nxt.clk_en    = (r_nxt.state != lcr_pkg::LCR_ST_OFF); // RL3
		r_nxt.bnd_rst   = (r_nxt.state != lcr_pkg::LCR_ST_RUN); // RL4

		// software bit requests in every select setting; a low pin still
		// wins unless the select ignores the pins
		r_nxt.sync_req = !r_r.sync_n || pin_req; // RL16 RL17
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r.en        <= lcr_pkg::LCR_RST_ENABLE[0]; // RL1
			r_r.mode      <= lcr_pkg::LCR_RST_MODE[5:0]; // RL8
			r_r.km1       <= lcr_pkg::LCR_RST_KM1; // RL11
			r_r.sync_n    <= lcr_pkg::LCR_RST_SYNC[0];
			r_r.fmt       <= lcr_pkg::LCR_RST_FMT[4:0];
			r_r.cal       <= lcr_pkg::LCR_RST_CAL[0];
			r_r.state     <= lcr_pkg::LCR_ST_OFF;
			r_r.mode_app  <= lcr_pkg::LCR_RST_MODE[5:0];
			r_r.km1_app   <= lcr_pkg::LCR_RST_KM1;
			r_r.rdata     <= '0;
			r_r.ready     <= 1'b0;
			r_r.slverr    <= 1'b0;
			r_r.sync_req  <= 1'b0;
			r_r.sub_rst_n <= 1'b0;
			r_r.pwr_down  <= 1'b1;
			r_r.clk_en    <= 1'b0;
			r_r.bnd_rst   <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign prdata                 = r_r.rdata;
	assign pready                 = r_r.ready;
	assign pslverr                = r_r.slverr;
	assign subsystem_reset_n      = r_r.sub_rst_n;
	assign serdes_power_down      = r_r.pwr_down;
	assign subsystem_clock_enable = r_r.clk_en;
	assign boundary_counter_reset = r_r.bnd_rst;
	assign applied_output_mode    = r_r.mode_app;
	assign applied_is_64b66b      = dec_is64;
	assign effective_k            = k_val;
	assign sync_request           = r_r.sync_req;
	assign calibration_enable     = r_r.cal;
	assign link_format_control    = r_r.fmt;
endmodule
`default_nettype wire

// ==== lcr_regs_fix_note.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== lcr_regs_monitor.sv ====
// checker of the link control register bank: apb timing and bring-up sequence
// assumes one pclk domain; bound to every lcr_regs instance
`timescale 1ns/1ps
`default_nettype none
module lcr_regs_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sync_pin_se_n,
	input wire logic        sync_pin_tmstp_n,
	input wire logic        subsystem_reset_n,
	input wire logic        serdes_power_down,
	input wire logic        subsystem_clock_enable,
	input wire logic        boundary_counter_reset,
	input wire logic        applied_is_64b66b,
	input wire logic [11:0] effective_k,
	input wire logic        sync_request,
	input wire logic [4:0]  link_format_control
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr_acc;
	logic       mapped;
	logic       exp_sync;
	logic [7:0] km1_r;
	logic       sync_r;
	assign wr_acc = psel && penable && pready && pwrite && pstrb[0];
	assign mapped = paddr inside {12'h800, 12'h804, 12'h808, 12'h80C, 12'h810, 12'h840, 12'h844};
	always_comb begin
		exp_sync = !sync_r;
		if (link_format_control[3:2] == 2'h0 && !sync_pin_se_n)
			exp_sync = 1'h1;
		if (link_format_control[3:2] == 2'h1 && !sync_pin_tmstp_n)
			exp_sync = 1'h1;
	end
	// shadows of host length and sync writes; exp_sync still takes the select from link_format_control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			km1_r <= 8'h1F;
			sync_r <= 1'h1;
		end else if (wr_acc && paddr == 12'h808) begin
			km1_r <= pwdata[7:0];
		end else if (wr_acc && paddr == 12'h80C) begin
			sync_r <= pwdata[0];
		end
	end
	property p_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
	property p_err;
		pready |-> pslverr == !mapped;
	endproperty
	a_err: assert property (p_err) else $error("error response wrong for address");
	property p_mode_rsv;
		pready && !pwrite && paddr == 12'h804 |-> prdata[31:6] == 26'h0;
	endproperty
	a_mode_rsv: assert property (p_mode_rsv) else $error("mode reserved bits read nonzero");
	property p_off;
		wr_acc && paddr == 12'h800 && !pwdata[0] |-> ##2 (serdes_power_down && !subsystem_reset_n
			&& boundary_counter_reset && !subsystem_clock_enable);
	endproperty
	a_off: assert property (p_off) else $error("subsystem not off after disable");
	property p_clk;
		subsystem_clock_enable != serdes_power_down;
	endproperty
	a_clk: assert property (p_clk) else $error("clock gate and power down disagree");
	property p_bnd;
		boundary_counter_reset != subsystem_reset_n;
	endproperty
	a_bnd: assert property (p_bnd) else $error("boundary counter out of reset early");
	property p_on;
		wr_acc && paddr == 12'h800 && pwdata[0] && !subsystem_clock_enable
			|-> ##2 subsystem_clock_enable;
	endproperty
	a_on: assert property (p_on) else $error("clocks not started after enable");
	property p_run;
		$rose(subsystem_clock_enable) |-> !subsystem_reset_n [*2] ##1 subsystem_reset_n;
	endproperty
	a_run: assert property (p_run) else $error("bring-up not three edges");
	property p_k;
		$rose(subsystem_reset_n) && !applied_is_64b66b |-> effective_k == {4'h0, km1_r} + 12'h001;
	endproperty
	a_k: assert property (p_k) else $error("multiframe length not stored plus one");
	property p_sync;
		$past(presetn) |-> sync_request == $past(exp_sync);
	endproperty
	a_sync: assert property (p_sync) else $error("sync request wrong");
endmodule
bind lcr_regs lcr_regs_monitor i_lcr_regs_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin_se_n(sync_pin_se_n),
	.sync_pin_tmstp_n(sync_pin_tmstp_n), .subsystem_reset_n(subsystem_reset_n),
	.serdes_power_down(serdes_power_down), .subsystem_clock_enable(subsystem_clock_enable),
	.boundary_counter_reset(boundary_counter_reset), .applied_is_64b66b(applied_is_64b66b),
	.effective_k(effective_k), .sync_request(sync_request),
	.link_format_control(link_format_control));
`default_nettype wire

// ==== tb_lcr_regs.sv ====
// self-checking bench of the link control register bank
// assumes the apb slave answers on its own; the bench waits with a bound
`timescale 1ns/1ps
`default_nettype none
module tb_lcr_regs;
	typedef struct packed {logic [11:0] a; logic w; logic [31:0] d;
		logic [31:0] x; logic e;} lcr_row_s;
	logic        pclk = 1'h0;
	logic        presetn, psel, penable, pwrite, se_n, tm_n;
	logic [11:0] paddr, k;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr, rst_n, pd, clk_en, bnd, is64, sreq, cal, er;
	logic [5:0]  mode;
	logic [4:0]  fmt;
	int          miscompares = 0;
	int          comparisons = 0;
	lcr_row_s    rows [15];
	always #2 pclk = ~pclk;
	lcr_regs i_lcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_pin_se_n(se_n), .sync_pin_tmstp_n(tm_n),
		.subsystem_reset_n(rst_n), .serdes_power_down(pd), .subsystem_clock_enable(clk_en),
		.boundary_counter_reset(bnd), .applied_output_mode(mode), .applied_is_64b66b(is64),
		.effective_k(k), .sync_request(sreq), .calibration_enable(cal), .link_format_control(fmt));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// no local limit: only the watchdog ends a wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// whole run is near 130 cycles; far beyond that means a hang
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{se_n, tm_n, pstrb} = 6'h3F;
		// reads first, then disable, cal clear, config, cal set
		rows = '{'{12'h800, 0, 0, 1, 0}, '{12'h804, 0, 0, 0, 0}, '{12'h808, 0, 0, 32'h1F, 0},
			'{12'h80C, 0, 0, 1, 0}, '{12'h810, 0, 0, 3, 0}, '{12'h840, 0, 0, 0, 0},
			'{12'h800, 1, 0, 0, 0}, '{12'h840, 1, 0, 0, 0}, '{12'h804, 1, 32'h3F, 0, 0},
			'{12'h808, 1, 32'h0F, 0, 0}, '{12'h804, 0, 0, 32'h3F, 0}, '{12'h808, 0, 0, 32'h0F, 0},
			'{12'h840, 1, 1, 0, 0}, '{12'hFFC, 1, 0, 0, 1}, '{12'hFFC, 0, 0, 0, 1}};
		repeat (16) @(posedge pclk);
		chk(32'({pd, clk_en, bnd, rst_n}), 32'hA);
		presetn <= 1'h1;
		repeat (5) @(posedge pclk);
		chk(32'({rst_n, k}), 32'h1020);
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			chk(32'(er), 32'(rows[i].e));
			if (!rows[i].w)
				chk(rd, rows[i].x);
		end
		// write without byte lane 0 must be dropped
		pstrb <= 4'hE;
		apb(12'h808, 1'h1, 32'h55);
		pstrb <= 4'hF;
		apb(12'h808, 1'h0, 32'h0);
		chk(rd, 32'h0F);
		apb(12'h800, 1'h1, 32'h1);
		repeat (5) @(posedge pclk);
		chk(32'({rst_n, mode, k}), 32'h7F010);
		chk(32'({is64, cal, fmt}), 32'h23);
		apb(12'h844, 1'h0, 32'h0);
		chk(rd, 32'h0010_0001);
		apb(12'h800, 1'h1, 32'h0);
		repeat (2) @(posedge pclk);
		chk(32'({pd, clk_en, bnd, rst_n}), 32'hA);
		apb(12'h840, 1'h1, 32'h0);
		apb(12'h80C, 1'h1, 32'h0);
		repeat (2) @(posedge pclk);
		chk(32'(sreq), 32'h1);
		apb(12'h80C, 1'h1, 32'h1);
		se_n <= 1'h0;
		repeat (2) @(posedge pclk);
		chk(32'(sreq), 32'h1);
		apb(12'h810, 1'h1, 32'h0B);
		repeat (2) @(posedge pclk);
		chk(32'(sreq), 32'h0);
		// reserved select 3 must ignore the pins as well
		apb(12'h810, 1'h1, 32'h0F);
		repeat (2) @(posedge pclk);
		chk(32'(sreq), 32'h0);
		chk(32'(fmt), 32'h0F);
		apb(12'h80C, 1'h1, 32'h0);
		repeat (2) @(posedge pclk);
		chk(32'(sreq), 32'h1);
		apb(12'h80C, 1'h1, 32'h1);
		apb(12'h810, 1'h1, 32'h07);
		{se_n, tm_n} <= 2'h1;
		repeat (2) @(posedge pclk);
		chk(32'(sreq), 32'h0);
		// reset in mid-run must restore the length and sync bit defaults
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(12'h808, 1'h0, 32'h0);
		chk(rd, 32'h1F);
		apb(12'h80C, 1'h0, 32'h0);
		chk(rd, 32'h1);
		conclude();
	end
endmodule
`default_nettype wire
